/* verilog/tpc_pkg.sv */
// package: register map, field layout, reset values and counts for the pwm/carrier timer
package tpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the apb slave
  localparam logic [11:0] TPC_OFS_MODE   = 12'h000;
  localparam logic [11:0] TPC_OFS_PERIOD = 12'h004;
  localparam logic [11:0] TPC_OFS_DUTY   = 12'h008;
  localparam logic [11:0] TPC_OFS_STATUS = 12'h00c;

  ////////////////////////////////////////////////////////////////////////////
  // timer_mode_reg field positions
  localparam int TPC_BIT_OE      = 0;
  localparam int TPC_BIT_DEFLVL  = 1;
  localparam int TPC_BIT_MODE_LO = 2;
  localparam int TPC_BIT_MODE_HI = 3;
  localparam int TPC_BIT_CKS_LO  = 4;
  localparam int TPC_BIT_CKS_HI  = 6;
  localparam int TPC_BIT_EN      = 7;

  // status register field positions
  localparam int TPC_ST_CNT_LO  = 0;
  localparam int TPC_ST_PHASE   = 8;
  localparam int TPC_ST_WAVE    = 9;
  localparam int TPC_ST_PEND    = 10;
  localparam int TPC_ST_DUTY_LO = 16;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] TPC_MODE_RST   = 8'h00;
  localparam logic [7:0] TPC_PERIOD_RST = 8'hff;
  localparam logic [7:0] TPC_DUTY_RST   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // count clock dividers and duty transfer holdoff
  localparam logic [2:0]  TPC_XFER_TICKS = 3'd3;
  localparam logic [5:0]  TPC_DIV_MASK2  = 6'h01;
  localparam logic [5:0]  TPC_DIV_MASK4  = 6'h03;
  localparam logic [5:0]  TPC_DIV_MASK16 = 6'h0f;
  localparam logic [5:0]  TPC_DIV_MASK64 = 6'h3f;
  localparam logic [10:0] TPC_SLOW_MASK  = 11'h7ff;

  typedef enum logic [2:0] {
    TPC_CKS_DIV1    = 3'h0,
    TPC_CKS_DIV2    = 3'h1,
    TPC_CKS_DIV4    = 3'h2,
    TPC_CKS_DIV16   = 3'h3,
    TPC_CKS_DIV64   = 3'h4,
    TPC_CKS_SLOW2K  = 3'h5
  } tpc_cks_e;

  typedef enum logic [1:0] {
    TPC_MODE_INTERVAL = 2'h0,
    TPC_MODE_CARRIER  = 2'h1,
    TPC_MODE_PWM      = 2'h2
  } tpc_mode_e;

  // gray along idle -> period -> duty -> period
  typedef enum logic [1:0] {
    TPC_ST_IDLE   = 2'b00,
    TPC_ST_PERCMP = 2'b01,
    TPC_ST_DUTCMP = 2'b11
  } tpc_state_e;

endpackage

/* verilog/tpc_clk_div.sv */
// count clock prescaler: one-cycle tick at the selected division
module tpc_clk_div
  import tpc_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       run,
  input  wire logic [2:0] sel,
  input  wire logic       slow_tick,
  // count clock
  output logic            tick
);

  logic [5:0]  div_reg;
  logic [10:0] slow_reg;
  logic        tick_reg;
  wire         tick_next;

  // prohibited codes give no tick at all
  function automatic logic sel_tick(input logic [2:0] s, input logic [5:0] d,
                                    input logic [10:0] sl, input logic st);
    case (s)
      TPC_CKS_DIV1:   sel_tick = 1'b1;
      TPC_CKS_DIV2:   sel_tick = (d & TPC_DIV_MASK2) == TPC_DIV_MASK2;
      TPC_CKS_DIV4:   sel_tick = (d & TPC_DIV_MASK4) == TPC_DIV_MASK4;
      TPC_CKS_DIV16:  sel_tick = (d & TPC_DIV_MASK16) == TPC_DIV_MASK16;
      TPC_CKS_DIV64:  sel_tick = d == TPC_DIV_MASK64;
      TPC_CKS_SLOW2K: sel_tick = st && (sl == TPC_SLOW_MASK);
      default:        sel_tick = 1'b0;
    endcase
  endfunction

  assign tick_next = run && sel_tick(sel, div_reg, slow_reg, slow_tick); // [RULE_20]
  assign tick      = tick_reg;

  // dividers restart with the channel so the first period is full length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= 6'h00;
      slow_reg <= 11'h000;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= run ? div_reg + 6'h01 : 6'h00;
      slow_reg <= !run ? 11'h000 : (slow_tick ? slow_reg + 11'h001 : slow_reg);
      tick_reg <= tick_next;
    end
  end

endmodule

/* verilog/tpc_duty_buf.sv */
// double buffer for the duty compare value with a three-tick transfer holdoff
module tpc_duty_buf
  import tpc_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // software write
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  // timer side
  input  wire logic       running,
  input  wire logic       tick,
  input  wire logic       duty_match,
  output logic [7:0]      active,
  output logic            pending,
  output logic [2:0]      age
);

  logic [7:0] buf_reg;
  logic [7:0] active_reg;
  logic       pend_reg;
  logic [2:0] age_reg;
  wire        aged;
  wire        xfer;

  assign aged    = age_reg == TPC_XFER_TICKS;
  assign xfer    = pend_reg && aged && duty_match;            // [RULE_06] [RULE_07]
  assign active  = active_reg;
  assign pending = pend_reg;
  assign age     = age_reg;

  // write and count clock share pclk, so a write at any phase is safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_reg    <= TPC_DUTY_RST;
      active_reg <= TPC_DUTY_RST;
      pend_reg   <= 1'b0;
      age_reg    <= 3'd0;
    end else if (wr && !running) begin
      active_reg <= wdata;
      buf_reg    <= wdata;
      pend_reg   <= 1'b0;
      age_reg    <= 3'd0;
    end else if (wr) begin                                   // [RULE_08]
      buf_reg  <= wdata;
      pend_reg <= 1'b1;
      age_reg  <= 3'd0;
    end else begin
      if (xfer) begin
        active_reg <= buf_reg;
        pend_reg   <= 1'b0;
      end
      if (tick && pend_reg && !aged)
        age_reg <= age_reg + 3'd1;                           // [RULE_07]
    end
  end

endmodule

/* verilog/tpc_top.sv */
// pwm / carrier timer channel with apb registers
//
// Overview of operation
// [RULE_01] counter starts on the selected count clock only after enable is set
// [RULE_02] first compare after enable uses the period compare value
// [RULE_03] pwm period match: invert output, clear counter, pulse irq, go to duty
// [RULE_04] pwm duty match: invert output, back to period, no clear, no irq
// [RULE_05] pwm period is n+1 counts, inactive:active ratio m+1 : n+1; the code holds the inverted level m+1 counts and the default level n-m
// [RULE_06] duty writes while counting wait in a buffer until the old duty matches
// [RULE_07] transfer needs three count clocks after the write
// [RULE_08] duty writes are accepted at any count clock phase
// [RULE_09] software leaves period compare alone while pwm is counting
// [RULE_10] software rewrites duty compare at every restart
// [RULE_11] software keeps duty below period, period at most ff
// [RULE_12] clearing enable returns irq and output to default at once
// [RULE_13] output holds its default level until the first match
// [RULE_14] carrier mode: period sets low width, duty sets high width
// [RULE_15] carrier mode: software may change duty but not period while running
// [RULE_16] carrier appears on the pin only while the companion gate allows
// [RULE_17] mode field: 00 interval, 01 carrier, 10 pwm, 11 prohibited
// [RULE_18] default level bit sets the idle output level
// [RULE_19] output pin is driven only while output enable is set
// [RULE_20] clock select: div 1,2,4,16,64 or slow clock div 2048
// [RULE_21] counter steps by one per tick, held at zero when disabled
// [RULE_22] irq is a one count clock pulse per qualifying match
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
module tpc_top (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // slow clock tick and carrier gate from the companion counter
  input  wire logic        slow_tick,
  input  wire logic        carrier_gate,
  // timer pin and interrupt
  output logic             timer_wave_out,
  output logic             timer_wave_oe,
  output logic             period_match_irq
);
  import tpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  timer_mode_reg;
  logic [7:0]  period_compare_reg;
  logic [7:0]  cnt_reg;
  logic [7:0]  cnt_next;
  tpc_state_e  state_reg;
  tpc_state_e  state_next;
  logic        wave_reg;
  logic        wave_next;
  logic        irq_reg;
  logic        irq_next;
  logic        pin_reg;
  logic        oe_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  wire         tick;
  wire [7:0]   duty_compare;
  wire         duty_pend;
  wire [2:0]   duty_age;

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  wire         count_enable_bit   = timer_mode_reg[TPC_BIT_EN];
  wire [2:0]   clock_select_field = timer_mode_reg[TPC_BIT_CKS_HI:TPC_BIT_CKS_LO];
  wire [1:0]   mode_select_field  = timer_mode_reg[TPC_BIT_MODE_HI:TPC_BIT_MODE_LO];
  wire         default_level_bit  = timer_mode_reg[TPC_BIT_DEFLVL];
  wire         output_enable_bit  = timer_mode_reg[TPC_BIT_OE];

  wire         mode_pwm     = mode_select_field == TPC_MODE_PWM;     // [RULE_17]
  wire         mode_carrier = mode_select_field == TPC_MODE_CARRIER; // [RULE_17]

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire         setup    = psel && !penable;
  wire         access   = psel && penable;
  wire         wr_acc   = access && pwrite;
  wire         hit_mode = paddr == TPC_OFS_MODE;
  wire         hit_per  = paddr == TPC_OFS_PERIOD;
  wire         hit_duty = paddr == TPC_OFS_DUTY;
  wire         hit_stat = paddr == TPC_OFS_STATUS;
  wire         mapped   = hit_mode || hit_per || hit_duty || hit_stat;
  wire         duty_wr  = wr_acc && hit_duty;

  // while counting only the enable bit may change in the mode register
  wire [7:0]   mode_wdata = count_enable_bit ?
                            {pwdata[TPC_BIT_EN], timer_mode_reg[TPC_BIT_EN-1:0]} : pwdata[7:0];

  wire [31:0]  status_word = {8'h00, duty_compare, 5'h00, duty_pend, wave_reg,
                              state_reg == TPC_ST_DUTCMP, cnt_reg};
  wire [31:0]  rd_mux = hit_mode ? {24'h000000, timer_mode_reg} :
                        hit_per  ? {24'h000000, period_compare_reg} :
                        hit_duty ? {24'h000000, duty_compare} :
                        hit_stat ? status_word : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // count clock and duty buffer
  tpc_clk_div u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (count_enable_bit),
    .sel       (clock_select_field),
    .slow_tick (slow_tick),
    .tick      (tick)
  );

  wire cmp_duty   = state_reg == TPC_ST_DUTCMP;
  wire cmp_val_eq = cnt_reg == (cmp_duty ? duty_compare : period_compare_reg);
  wire hit_now    = count_enable_bit && tick && cmp_val_eq;
  wire per_hit    = hit_now && (state_reg == TPC_ST_PERCMP);
  wire duty_hit   = hit_now && cmp_duty;

  tpc_duty_buf u_duty (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr         (duty_wr),
    .wdata      (pwdata[7:0]),
    .running    (count_enable_bit),
    .tick       (tick),
    .duty_match (duty_hit),
    .active     (duty_compare),
    .pending    (duty_pend),
    .age        (duty_age)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare sequencer
  // interval mode never leaves the period compare; carrier clears on both matches
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    wave_next  = wave_reg;
    irq_next   = tick ? 1'b0 : irq_reg;                      // [RULE_22]
    case (state_reg)
      TPC_ST_IDLE: begin
        if (count_enable_bit)
          state_next = TPC_ST_PERCMP;                        // [RULE_02]
      end
      TPC_ST_PERCMP: begin
        if (per_hit) begin
          cnt_next  = 8'h00;                                 // [RULE_03] [RULE_05]
          wave_next = !wave_reg;
          irq_next  = 1'b1;
          if (mode_pwm || mode_carrier)
            state_next = TPC_ST_DUTCMP;
        end else if (tick) begin
          cnt_next = cnt_reg + 8'h01;                        // [RULE_01] [RULE_21]
        end
      end
      TPC_ST_DUTCMP: begin
        if (duty_hit) begin
          wave_next  = !wave_reg;                            // [RULE_04]
          state_next = TPC_ST_PERCMP;
          if (mode_carrier) begin
            cnt_next = 8'h00;                                // [RULE_14]
            irq_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 8'h01;                      // [RULE_05]
          end
        end else if (tick) begin
          cnt_next = cnt_reg + 8'h01;                        // [RULE_21]
        end
      end
      default: state_next = TPC_ST_IDLE;
    endcase
    if (!count_enable_bit) begin
      state_next = TPC_ST_IDLE;
      cnt_next   = 8'h00;                                    // [RULE_21]
      wave_next  = default_level_bit;                        // [RULE_12] [RULE_13] [RULE_18]
      irq_next   = 1'b0;                                     // [RULE_12]
    end
  end

  // outside carrier gating the pin follows the wave; gate closed forces low
  wire pin_next = (mode_carrier && !carrier_gate) ? 1'b0 : wave_next;   // [RULE_16]

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_reg     <= TPC_MODE_RST;
      period_compare_reg <= TPC_PERIOD_RST;
    end else if (wr_acc) begin
      if (hit_mode)
        timer_mode_reg <= mode_wdata;
      if (hit_per)
        period_compare_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= TPC_ST_IDLE;
      cnt_reg   <= 8'h00;
      wave_reg  <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      wave_reg  <= wave_next;
      irq_reg   <= irq_next;
    end
  end

  // pin is registered from wave_next, so it changes on the same edge as wave; disabled output is not driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else begin
      pin_reg <= output_enable_bit ? pin_next : 1'b0;        // [RULE_19]
      oe_reg  <= output_enable_bit;                          // [RULE_19]
    end
  end

  // read data is captured in setup so the access phase needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (setup) begin
        prdata_reg  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_reg <= !mapped;
      end
    end
  end

  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign timer_wave_out   = pin_reg;
  assign timer_wave_oe    = oe_reg;
  assign period_match_irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_pwm_period_hit;
    mode_pwm && per_hit;
  endsequence

  sequence s_pwm_duty_hit;
    mode_pwm && duty_hit && count_enable_bit;
  endsequence

  cnt_held_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_21]
    !count_enable_bit |=> cnt_reg == 8'h00)
    else $error("counter not held at zero while disabled");

  cnt_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
    count_enable_bit && !tick && $past(count_enable_bit) |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved without a count tick");

  first_cmp_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
    state_reg == TPC_ST_IDLE && count_enable_bit |=> state_reg == TPC_ST_PERCMP)
    else $error("first compare is not the period compare");

  period_hit_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
    s_pwm_period_hit |=> cnt_reg == 8'h00 && irq_reg && wave_reg != $past(wave_reg)
                         && state_reg == TPC_ST_DUTCMP)
    else $error("period match actions wrong");

  duty_hit_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
    s_pwm_duty_hit |=> !irq_reg && wave_reg != $past(wave_reg)
                       && cnt_reg == $past(cnt_reg) + 8'h01 && state_reg == TPC_ST_PERCMP)
    else $error("duty match actions wrong");

  stop_default_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
    $fell(count_enable_bit) |=> !irq_reg && wave_reg == $past(default_level_bit))
    else $error("stop did not return to default");

  early_xfer_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
    duty_pend && duty_age < TPC_XFER_TICKS && !duty_wr |=> duty_compare == $past(duty_compare))
    else $error("duty transferred before three count clocks");

  duty_buffered_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
    duty_wr && count_enable_bit |=> duty_pend && duty_compare == $past(duty_compare))
    else $error("running duty write not buffered");

  pin_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_19]
    !output_enable_bit |=> !timer_wave_oe && !timer_wave_out)
    else $error("pin driven with output disabled");

  gate_closed_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
    mode_carrier && !carrier_gate |=> !timer_wave_out)
    else $error("carrier leaked with gate closed");

  irq_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_22]
    irq_reg && tick && !hit_now |=> !irq_reg)
    else $error("irq longer than one count clock");

endmodule

/* verification/tpc_pin_load.sv */
// pin load model: resolves the timer pin and measures its pulse widths
module tpc_pin_load (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // timer pin as driven by the block
  input  wire logic        timer_wave_out,
  input  wire logic        timer_wave_oe,
  // observed line and measurements in pclk cycles
  output logic             pin,
  output logic [15:0]      rises,
  output logic [15:0]      falls,
  output logic [15:0]      high_len,
  output logic [15:0]      period_len
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        pin_d;
  logic [15:0] hi_run;
  logic [15:0] per_run;

  ////////////////////////////////////////////////////////////////////////////
  // pull-down on the line: an undriven pin reads low, never the last level
  assign pin = timer_wave_oe ? timer_wave_out : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // width counters; a rise restarts both runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d      <= 1'b0;
      hi_run     <= 16'h0000;
      per_run    <= 16'h0000;
      rises      <= 16'h0000;
      falls      <= 16'h0000;
      high_len   <= 16'h0000;
      period_len <= 16'h0000;
    end else begin
      pin_d   <= pin;
      per_run <= per_run + 16'h0001;
      hi_run  <= hi_run + 16'h0001;
      if (pin && !pin_d) begin
        period_len <= per_run;
        per_run    <= 16'h0001;
        hi_run     <= 16'h0001;
        rises      <= rises + 16'h0001;
      end
      if (!pin && pin_d) begin
        high_len <= hi_run;
        falls    <= falls + 16'h0001;
      end
    end
  end
endmodule

/* verification/tpc_top_test.sv */
// self-checking bench for the pwm / carrier timer channel
module tpc_top_test;
  import tpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [2:0] cks;
    logic [1:0] md;
    logic [7:0] n;
    logic [7:0] m;
    int         hi;
    int         per;
    int         irq;
  } tpc_row_s;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slow_tick = 1'b0;
  logic        carrier_gate;
  logic        timer_wave_out;
  logic        timer_wave_oe;
  logic        period_match_irq;
  logic        pin;
  logic [15:0] rises;
  logic [15:0] falls;
  logic [15:0] high_len;
  logic [15:0] period_len;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          num_checks;
  int          irq_run = 0;
  int          irq_len = 0;

  // slow row: 2048 slow pulses, one every two pclk, so 4096 pclk per count tick
  // interval row: wave toggles on each period match only, so high is n+1 ticks
  tpc_row_s rows[9] = '{
    '{3'h0, 2'h2, 8'h03, 8'h01, 2, 4, 1},
    '{3'h0, 2'h2, 8'hff, 8'h00, 1, 256, 1},
    '{3'h1, 2'h2, 8'h05, 8'h02, 6, 12, 2},
    '{3'h2, 2'h2, 8'h02, 8'h01, 8, 12, 4},
    '{3'h3, 2'h2, 8'h01, 8'h00, 16, 32, 16},
    '{3'h4, 2'h2, 8'h01, 8'h00, 64, 128, 64},
    '{3'h5, 2'h2, 8'h01, 8'h00, 4096, 8192, 4096},
    '{3'h0, 2'h0, 8'h03, 8'h01, 4, 8, 1},
    '{3'h0, 2'h1, 8'h04, 8'h02, 3, 8, 1}
  };

  tpc_top i_tpc_top (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .slow_tick        (slow_tick),
    .carrier_gate     (carrier_gate),
    .timer_wave_out   (timer_wave_out),
    .timer_wave_oe    (timer_wave_oe),
    .period_match_irq (period_match_irq)
  );

  tpc_pin_load i_tpc_pin_load (
    .pclk           (pclk),
    .presetn        (presetn),
    .timer_wave_out (timer_wave_out),
    .timer_wave_oe  (timer_wave_oe),
    .pin            (pin),
    .rises          (rises),
    .falls          (falls),
    .high_len       (high_len),
    .period_len     (period_len)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    slow_tick <= ~slow_tick;
    if (period_match_irq === 1'b1) begin
      irq_run <= irq_run + 1;
    end else if (irq_run != 0) begin
      irq_len <= irq_run;
      irq_run <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // settle past the edge so registered outputs are read after they land
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (period_match_irq !== 1'b1 && k < 5000) begin
      tick(1);
      k++;
    end
    if (k >= 5000) fails++;
  endtask

  task automatic wait_edge(input bit fall, input int n);
    int k;
    logic [15:0] target;
    k = 0;
    target = (fall ? falls : rises) + 16'(n);
    while ((fall ? falls : rises) != target && k < 30000) begin
      tick(1);
      k++;
    end
    if (k >= 30000) fails++;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    carrier_gate = 1'b1;
    fails = 0;
    num_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    chk({pready, timer_wave_out, timer_wave_oe, period_match_irq}, 32'h8);
    apb(1'b0, TPC_OFS_MODE, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, TPC_OFS_PERIOD, 32'h0);
    chk(rd, 32'h0000_00ff);
    apb(1'b0, TPC_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    // every clock select and all three modes
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, TPC_OFS_MODE, 32'h0);
      apb(1'b1, TPC_OFS_PERIOD, {24'h0, rows[i].n});
      apb(1'b1, TPC_OFS_DUTY, {24'h0, rows[i].m});
      apb(1'b1, TPC_OFS_MODE, {24'h0, 1'b1, rows[i].cks, rows[i].md, 1'b0, 1'b1});
      wait_edge(1'b0, 3);
      chk({16'h0, high_len}, 32'(rows[i].hi));
      chk({16'h0, period_len}, 32'(rows[i].per));
      chk(32'(irq_len), 32'(rows[i].irq));
    end
    // closed gate keeps the running carrier off the pin
    @(posedge pclk);
    carrier_gate <= 1'b0;
    repeat (20) begin
      tick(1);
      chk({31'h0, timer_wave_out}, 32'h0);
    end
    // default level high; disable while the irq pulse stands
    apb(1'b1, TPC_OFS_MODE, 32'h0);
    apb(1'b1, TPC_OFS_PERIOD, 32'h28);
    apb(1'b1, TPC_OFS_DUTY, 32'h0a);
    apb(1'b1, TPC_OFS_MODE, 32'h3b);
    tick(3);
    chk({31'h0, timer_wave_out}, 32'h1);
    apb(1'b1, TPC_OFS_MODE, 32'hbb);
    repeat (20) begin
      tick(1);
      chk({31'h0, timer_wave_out}, 32'h1);
    end
    wait_irq();
    apb(1'b1, TPC_OFS_MODE, 32'h3b);
    tick(2);
    chk({30'h0, period_match_irq, timer_wave_out}, 32'h1);
    apb(1'b0, TPC_OFS_STATUS, 32'h0);
    chk(rd & 32'h0000_00ff, 32'h0);
    apb(1'b1, TPC_OFS_MODE, 32'h3a);
    tick(2);
    chk({30'h0, timer_wave_oe, timer_wave_out}, 32'h0);
    // late duty write misses one match, then lands at the next
    apb(1'b1, TPC_OFS_MODE, 32'h0);
    apb(1'b1, TPC_OFS_PERIOD, 32'h14);
    apb(1'b1, TPC_OFS_DUTY, 32'h05);
    apb(1'b1, TPC_OFS_MODE, 32'hb9);
    wait_irq();
    tick(66);
    apb(1'b1, TPC_OFS_DUTY, 32'h0a);
    apb(1'b0, TPC_OFS_DUTY, 32'h0);
    chk(rd, 32'h05);
    apb(1'b0, TPC_OFS_STATUS, 32'h0);
    chk({31'h0, rd[TPC_ST_PEND]}, 32'h1);
    wait_edge(1'b1, 1);
    chk({16'h0, high_len}, 32'd96);
    wait_edge(1'b1, 1);
    chk({16'h0, high_len}, 32'd96);
    apb(1'b0, TPC_OFS_DUTY, 32'h0);
    chk(rd, 32'h0a);
    wait_edge(1'b1, 1);
    chk({16'h0, high_len}, 32'd176);
    // reset in mid-run: outputs drop at once, counting state is gone after release
    @(posedge pclk);
    presetn <= 1'b0;
    tick(2);
    chk({pready, timer_wave_out, timer_wave_oe, period_match_irq}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    chk({pready, timer_wave_out, timer_wave_oe, period_match_irq}, 32'h8);
    apb(1'b0, TPC_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h0);
    conclude();
  end
endmodule
